// file: design/sfs_pkg.sv
// Purpose: shared constants for the serial flash status/command block
// Assumes: 64 KByte array, 8-bit bus cycles
// Notes:   opcodes, status bit positions, power-up values, erase masks
package sfs_pkg;

  // opcodes
  localparam logic [7:0] OP_READ   = 8'h03;
  localparam logic [7:0] OP_PROG   = 8'h02;
  localparam logic [7:0] OP_SECT   = 8'h20;
  localparam logic [7:0] OP_BLOCK  = 8'h52;
  localparam logic [7:0] OP_CHIP   = 8'h60;
  localparam logic [7:0] OP_AAI    = 8'hAF;
  localparam logic [7:0] OP_ST_RD  = 8'h05;
  localparam logic [7:0] OP_ST_ARM = 8'h50;
  localparam logic [7:0] OP_ST_WR  = 8'h01;
  localparam logic [7:0] OP_WR_EN  = 8'h06;
  localparam logic [7:0] OP_WR_DIS = 8'h04;
  localparam logic [7:0] OP_ID_A   = 8'h90;
  localparam logic [7:0] OP_ID_B   = 8'hAB;

  // status word bit positions
  localparam int ST_BUSY  = 0;
  localparam int ST_WEL   = 1;
  localparam int ST_BP_LO = 2;
  localparam int ST_BP_HI = 3;
  localparam int ST_AAI   = 6;
  localparam int ST_LOCK  = 7;

  // power-up values
  localparam logic       RST_WEL  = 1'b0;
  localparam logic [1:0] RST_BP   = 2'h3;
  localparam logic       RST_LOCK = 1'b0;
  localparam logic       RST_AAI  = 1'b0;

  // array geometry and protection bases
  localparam int          ADDR_W     = 16;
  localparam logic [15:0] PROT_L1    = 16'hC000;
  localparam logic [15:0] PROT_L2    = 16'h8000;
  localparam logic [15:0] SECT_MASK  = 16'h0FFF;
  localparam logic [15:0] BLOCK_MASK = 16'h7FFF;
  localparam logic [15:0] CHIP_MASK  = 16'hFFFF;
  localparam logic [7:0]  ERASED     = 8'hFF;

  // bus cycles per instruction
  localparam logic [2:0] LEN_ONE   = 3'h1;
  localparam logic [2:0] LEN_TWO   = 3'h2;
  localparam logic [2:0] LEN_ADDR  = 3'h4;
  localparam logic [2:0] LEN_FULL  = 3'h5;
  localparam logic [2:0] LAST_ADDR = 3'h3;

  // queued array operations
  typedef enum logic [1:0] {
    EOP_PROG  = 2'b00,
    EOP_SECT  = 2'b01,
    EOP_BLOCK = 2'b10,
    EOP_CHIP  = 2'b11
  } sfs_eop_e;

  // array engine states
  typedef enum logic [1:0] {
    ENG_IDLE  = 2'b00,
    ENG_PROG  = 2'b01,
    ENG_ERASE = 2'b10
  } sfs_eng_e;

  localparam int FIFO_W = 2 + ADDR_W + 8;

endpackage

// file: design/sfs_sync.sv
// Purpose: two-flop synchroniser for pin inputs
// Assumes: inputs are levels, slow against sys_clk_i
// Notes:   first stage feeds only the second
`timescale 1ns/1ps
module sfs_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             sys_clk_i,
  input  wire logic             arst_n_i,
  // data
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_q;

  // both stages reset to zero
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      meta_q <= '0;
      sync_o <= '0;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end

endmodule

// file: design/sfs_fifo.sv
// Purpose: queue of array operations waiting for the engine
// Assumes: depth is a power of two
// Notes:   full and empty from pointers with a wrap bit
`timescale 1ns/1ps
module sfs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             sys_clk_i,
  input  wire logic             arst_n_i,
  // fill side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // drain side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);

  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("sfs_fifo: DEPTH must be a power of two");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_q;
  logic [AW:0]      rd_q;
  logic             push;
  logic             pop;

  assign in_ready_o  = (wr_q ^ rd_q) != {1'b1, {AW{1'b0}}};
  assign out_valid_o = wr_q != rd_q;
  assign out_data_o  = mem[rd_q[AW-1:0]];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  // storage has no reset, only pointers matter
  always_ff @(posedge sys_clk_i) begin
    if (push) begin
      mem[wr_q[AW-1:0]] <= in_data_i;
    end
  end

  // pointers
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end

endmodule

// file: design/sfs_flash_ctrl.sv
// Purpose: spi serial flash command decoder, status word and array
// Assumes: spi pins asynchronous to sys_clk_i, sck well below clk/4
// Notes:   array content is undefined until erased
`timescale 1ns/1ps

// What this block does
// - busy is 1 during program or erase
// - no program or erase without write enable
// - write enable clears on power-up and when a byte program or erase is accepted, while busy is still 1
// - status write allowed if pin high or unlocked
// - chip erase only when protection level zero
// - power-up: protection level three, lock cleared
// - pin low and locked freezes protection bits
// - pin high makes the lock bit meaningless
// - protection levels map to upper address ranges
// - level one does not guard block erase
// - status word bit layout
// - auto-increment flag reports programming mode
// - bytes are eight bits, msb first, rising edge
// - instruction starts at select falling edge
// - early deselect abandons the instruction
// - read and byte program cycle layout
// - erase opcodes and significant address bits
// - auto-increment first and follow-on layouts
// - status read repeats until deselect
// - status write only right after arming
// - id read selects code by address bit
// - sample rising, drive after falling edge
// - write disable clears enable and auto-increment
// - auto-increment stops at highest unprotected address
module sfs_flash_ctrl #(
  parameter int         PROG_CYCLES = 16,
  parameter int         FIFO_DEPTH  = 16,
  parameter logic [7:0] MFR_CODE    = 8'hA5, // arbitrary value
  parameter logic [7:0] DEV_CODE    = 8'h5A  // arbitrary value
) (
  // clock and reset
  input  wire logic sys_clk_i,
  input  wire logic arst_n_i,
  // spi pins
  input  wire logic sck_i,
  input  wire logic cs_n_i,
  input  wire logic si_i,
  input  wire logic wp_n_i,
  output logic      so_o,
  output logic      so_oe_o
);

  import sfs_pkg::*;

  if (PROG_CYCLES < 1 || PROG_CYCLES > 65535) begin : g_bad_prog
    $error("sfs_flash_ctrl: PROG_CYCLES out of range");
  end

  logic [3:0]        pins_s;
  logic              sck_s, cs_n_s, si_s, wp_n_s;
  logic              sck_d_q, cs_d_q, sck_rise, sck_fall, cs_rise, byte_done, framed;
  logic [2:0]        bit_cnt_q, byte_cnt_q, aai_len;
  logic [6:0]        shift_q;
  logic [7:0]        rx_byte, cur_op, opcode_q, data_q, out_byte_q, stat_word;
  logic [15:0]       addr_q, full_addr, rd_ptr_q, aai_ptr_q, aai_addr, push_addr;
  logic              out_phase_q, so_q, so_oe_q, wel_q, lock_q, aai_q, arm_q, busy_q;
  logic [1:0]        bp_q;
  logic              st_wr_ok, push_valid, push_ready, accept, pop_valid, pop_ready;
  sfs_eop_e          push_op;
  logic [FIFO_W-1:0] pop_data;
  sfs_eng_e          eng_q;
  logic [15:0]       eng_addr_q, eng_end_q, eng_cnt_q;
  logic [7:0]        eng_data_q;
  logic [7:0]        mem [1 << ADDR_W];
  localparam logic [15:0] PROG_LAST = 16'(PROG_CYCLES - 1);

  // true when address a lies in the protected range of level lv
  function automatic logic is_prot(input logic [15:0] a, input logic [1:0] lv, input logic blk);
    unique case (lv)
      2'h0: is_prot = 1'b0;
      2'h1: is_prot = !blk && (a >= PROT_L1);
      2'h2: is_prot = a >= PROT_L2;
      2'h3: is_prot = 1'b1;
    endcase
  endfunction

  // highest address that auto-increment may still program
  function automatic logic [15:0] top_free(input logic [1:0] lv);
    unique case (lv)
      2'h1: top_free = PROT_L1 - 16'h0001;
      2'h2: top_free = PROT_L2 - 16'h0001;
      default: top_free = CHIP_MASK;
    endcase
  endfunction

  // pins pass two flops before any logic
  sfs_sync #(
    .WIDTH (4)
  ) u_sync (
    .sys_clk_i (sys_clk_i),
    .arst_n_i  (arst_n_i),
    .async_i   ({wp_n_i, si_i, ~cs_n_i, sck_i}),
    .sync_o    (pins_s)
  );

  assign sck_s  = pins_s[0];
  assign cs_n_s = ~pins_s[1]; // select synced active high, so reset reads deselected
  assign si_s   = pins_s[2];
  assign wp_n_s = pins_s[3];

  // edge history of the synchronised clock and select
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sck_d_q <= 1'b0;
      cs_d_q  <= 1'b1;
    end else begin
      sck_d_q <= sck_s;
      cs_d_q  <= cs_n_s;
    end
  end

  assign sck_rise  = sck_s & ~sck_d_q;
  assign sck_fall  = ~sck_s & sck_d_q;
  assign cs_rise   = cs_n_s & ~cs_d_q;
  assign byte_done = ~cs_n_s & sck_rise & (bit_cnt_q == 3'h7);
  assign rx_byte   = {shift_q, si_s};
  assign cur_op    = (byte_cnt_q == 3'h0) ? rx_byte : opcode_q;
  assign full_addr = {addr_q[7:0], rx_byte};
  // executes only on whole bus cycles
  assign framed    = cs_rise & (bit_cnt_q == 3'h0);

  // bit and byte counters, held clear while deselected
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bit_cnt_q  <= 3'h0;
      byte_cnt_q <= 3'h0;
      shift_q    <= 7'h00;
    end else if (cs_n_s) begin
      bit_cnt_q  <= 3'h0;
      byte_cnt_q <= 3'h0;
    end else if (sck_rise) begin
      bit_cnt_q <= bit_cnt_q + 3'h1;
      shift_q   <= rx_byte[6:0];
      if (bit_cnt_q == 3'h7 && byte_cnt_q != 3'h7) byte_cnt_q <= byte_cnt_q + 3'h1;
    end
  end

  // opcode, address and data capture per bus cycle
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      opcode_q <= 8'h00;
      addr_q   <= 16'h0000;
      data_q   <= 8'h00;
    end else if (byte_done) begin
      if (byte_cnt_q == 3'h0) opcode_q <= rx_byte;
      else data_q <= rx_byte;
      // upper address byte is beyond the array and dropped
      if (byte_cnt_q != 3'h0 && byte_cnt_q <= LAST_ADDR) addr_q <= full_addr;
    end
  end

  // read-only bits come from state, reserved bits read zero
  always_comb begin
    stat_word           = 8'h00;
    stat_word[ST_BUSY]  = busy_q;
    stat_word[ST_WEL]   = wel_q;
    stat_word[ST_BP_LO] = bp_q[0];
    stat_word[ST_BP_HI] = bp_q[1];
    stat_word[ST_AAI]   = aai_q;
    stat_word[ST_LOCK]  = lock_q;
  end

  // next outgoing byte, reloaded at each byte boundary
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      out_byte_q  <= 8'h00;
      out_phase_q <= 1'b0;
      rd_ptr_q    <= 16'h0000;
    end else if (cs_n_s) begin
      out_phase_q <= 1'b0;
    end else if (byte_done) begin
      if (cur_op == OP_ST_RD) begin
        out_byte_q  <= stat_word;
        out_phase_q <= 1'b1;
      end else if (cur_op == OP_READ && byte_cnt_q == LAST_ADDR) begin
        out_byte_q  <= mem[full_addr];
        rd_ptr_q    <= full_addr + 16'h0001;
        out_phase_q <= 1'b1;
      end else if (cur_op == OP_READ && byte_cnt_q > LAST_ADDR) begin
        // pointer wraps at the top of the array
        out_byte_q <= mem[rd_ptr_q];
        rd_ptr_q   <= rd_ptr_q + 16'h0001;
      end else if ((cur_op == OP_ID_A || cur_op == OP_ID_B) && byte_cnt_q == LAST_ADDR) begin
        out_byte_q  <= rx_byte[0] ? DEV_CODE : MFR_CODE;
        out_phase_q <= 1'b1;
      end
    end
  end

  // serial out changes only after falling sck
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      so_q    <= 1'b0;
      so_oe_q <= 1'b0;
    end else if (cs_n_s) begin
      so_oe_q <= 1'b0;
    end else if (sck_fall && out_phase_q) begin
      so_q    <= out_byte_q[~bit_cnt_q];
      so_oe_q <= 1'b1;
    end
  end

  assign so_o    = so_q;
  assign so_oe_o = so_oe_q;

  assign st_wr_ok = wp_n_s | ~lock_q;
  assign aai_addr = aai_q ? aai_ptr_q : addr_q;
  assign aai_len  = aai_q ? LEN_TWO : LEN_FULL;

  // decide which write commands reach the array queue
  always_comb begin
    push_valid = 1'b0;
    push_op    = EOP_PROG;
    push_addr  = addr_q;
    if (framed && wel_q) begin
      case (opcode_q)
        OP_PROG: push_valid = (byte_cnt_q == LEN_FULL) && !aai_q && !is_prot(addr_q, bp_q, 1'b0);
        OP_SECT: begin
          push_op    = EOP_SECT;
          push_addr  = addr_q & ~SECT_MASK;
          push_valid = (byte_cnt_q == LEN_ADDR) && !is_prot(push_addr, bp_q, 1'b0);
        end
        OP_BLOCK: begin
          push_op    = EOP_BLOCK;
          push_addr  = addr_q & ~BLOCK_MASK;
          push_valid = (byte_cnt_q == LEN_ADDR) && !is_prot(push_addr, bp_q, 1'b1);
        end
        OP_CHIP: begin
          push_op    = EOP_CHIP;
          push_addr  = 16'h0000;
          push_valid = (byte_cnt_q == LEN_ONE) && (bp_q == 2'h0);
        end
        OP_AAI: begin
          push_addr  = aai_addr;
          push_valid = (byte_cnt_q == aai_len) && !is_prot(aai_addr, bp_q, 1'b0);
        end
        default: push_valid = 1'b0;
      endcase
    end
  end

  // a full queue refuses the command, software sees busy
  assign accept = push_valid & push_ready;

  // status bits and the auto-increment pointer
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wel_q     <= RST_WEL;
      bp_q      <= RST_BP;
      lock_q    <= RST_LOCK;
      aai_q     <= RST_AAI;
      aai_ptr_q <= 16'h0000;
      arm_q     <= 1'b0;
    end else if (framed && byte_cnt_q != 3'h0) begin
      // arming lasts for exactly the next instruction
      arm_q <= (opcode_q == OP_ST_ARM) && (byte_cnt_q == LEN_ONE);
      if (opcode_q == OP_WR_EN && byte_cnt_q == LEN_ONE) wel_q <= 1'b1;
      if (opcode_q == OP_WR_DIS && byte_cnt_q == LEN_ONE) begin
        wel_q <= 1'b0;
        aai_q <= 1'b0;
      end
      if (opcode_q == OP_ST_WR && byte_cnt_q == LEN_TWO && arm_q && st_wr_ok) begin
        bp_q   <= {data_q[ST_BP_HI], data_q[ST_BP_LO]};
        lock_q <= data_q[ST_LOCK];
      end
      if (accept) wel_q <= 1'b0;
      if (accept && opcode_q == OP_AAI) begin
        aai_q     <= 1'b1;
        aai_ptr_q <= aai_addr + 16'h0001;
        wel_q     <= 1'b1;
        if (aai_addr == top_free(bp_q)) begin
          aai_q <= 1'b0;
          wel_q <= 1'b0;
        end
      end
    end
  end

  sfs_fifo #(
    .WIDTH (FIFO_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk_i   (sys_clk_i),
    .arst_n_i    (arst_n_i),
    .in_valid_i  (push_valid),
    .in_ready_o  (push_ready),
    .in_data_i   ({push_op, push_addr, data_q}),
    .out_valid_o (pop_valid),
    .out_ready_i (pop_ready),
    .out_data_o  (pop_data)
  );

  assign pop_ready = (eng_q == ENG_IDLE);

  // array engine: timed program or erase sweep, one queued operation at a time
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      eng_q      <= ENG_IDLE;
      eng_addr_q <= 16'h0000;
      eng_end_q  <= 16'h0000;
      eng_data_q <= 8'h00;
      eng_cnt_q  <= 16'h0000;
    end else begin
      unique case (eng_q)
        ENG_IDLE: begin
          eng_cnt_q  <= 16'h0000;
          eng_data_q <= pop_data[7:0];
          eng_addr_q <= pop_data[23:8];
          if (pop_valid) begin
            unique case (sfs_eop_e'(pop_data[25:24]))
              EOP_PROG: eng_q <= ENG_PROG;
              EOP_SECT: begin
                eng_end_q <= pop_data[23:8] | SECT_MASK;
                eng_q     <= ENG_ERASE;
              end
              EOP_BLOCK: begin
                eng_end_q <= pop_data[23:8] | BLOCK_MASK;
                eng_q     <= ENG_ERASE;
              end
              EOP_CHIP: begin
                eng_end_q <= CHIP_MASK;
                eng_q     <= ENG_ERASE;
              end
            endcase
          end
        end
        ENG_PROG: begin
          eng_cnt_q <= eng_cnt_q + 16'h0001;
          if (eng_cnt_q == PROG_LAST) eng_q <= ENG_IDLE;
        end
        ENG_ERASE: begin
          eng_addr_q <= eng_addr_q + 16'h0001;
          if (eng_addr_q == eng_end_q) eng_q <= ENG_IDLE;
        end
        default: eng_q <= ENG_IDLE;
      endcase
    end
  end

  // programming only clears bits, erase sets the byte
  always_ff @(posedge sys_clk_i) begin
    if (eng_q == ENG_PROG && eng_cnt_q == PROG_LAST) begin
      mem[eng_addr_q] <= mem[eng_addr_q] & eng_data_q;
    end else if (eng_q == ENG_ERASE) begin
      mem[eng_addr_q] <= ERASED;
    end
  end

  // busy while anything is queued or running
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= pop_valid | (eng_q != ENG_IDLE) | push_valid;
    end
  end

endmodule

// file: verif/sfs_flash_ctrl_monitor.sv
// Purpose: pin-level checks of the serial output driver
// Assumes: sck half period well above 4 sys clocks
// Notes:   sck rises counted at the pins, not behind the synchroniser
`timescale 1ns/1ps
module sfs_flash_ctrl_monitor #(
  parameter int PROG_CYCLES = 16,
  parameter int FIFO_DEPTH  = 16
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  // spi pins
  input wire logic sck_i,
  input wire logic cs_n_i,
  input wire logic si_i,
  input wire logic wp_n_i,
  input wire logic so_o,
  input wire logic so_oe_o
);
  logic       sck_q;
  logic [5:0] rise_q;

  // previous sck pin level, for edge finding
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) sck_q <= 1'b0;
    else sck_q <= sck_i;
  end

  // sck rises since select; saturates so long reads never wrap
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) rise_q <= 6'h00;
    else if (cs_n_i) rise_q <= 6'h00;
    else if (sck_i && !sck_q && rise_q != 6'h3F) rise_q <= rise_q + 6'h01;
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);

  a_oe_reset_off: assert property ($rose(arst_n_i) |-> !so_oe_o && !so_o)
    else $error("output driven right after reset");
  a_oe_deselect: assert property (cs_n_i [*8] |-> !so_oe_o)
    else $error("output enabled while deselected");
  a_oe_release: assert property ($rose(cs_n_i) |-> ##[1:6] !so_oe_o)
    else $error("output not released after deselect");
  a_oe_start_sel: assert property ($rose(so_oe_o) |-> !cs_n_i)
    else $error("output enabled without select");
  a_oe_start_low: assert property ($rose(so_oe_o) |-> !sck_i)
    else $error("output enabled outside sck low phase");
  a_oe_on_byte: assert property ($rose(so_oe_o) |-> rise_q == 6'h08 || rise_q == 6'h20)
    else $error("output phase not on a byte boundary");
  a_so_steady: assert property ((so_oe_o && sck_i) [*4] |-> $stable(so_o))
    else $error("data out changed while sck high");
  a_oe_holds: assert property ((so_oe_o && !cs_n_i) ##1 (!cs_n_i) [*3] |-> so_oe_o)
    else $error("output dropped while selected");

  c_status_read: cover property ($rose(so_oe_o) && rise_q == 6'h08);
  c_array_read: cover property ($rose(so_oe_o) && rise_q == 6'h20);
  c_mode_three: cover property ($rose(cs_n_i) && sck_i);
endmodule

bind sfs_flash_ctrl sfs_flash_ctrl_monitor #(
  .PROG_CYCLES(PROG_CYCLES),
  .FIFO_DEPTH (FIFO_DEPTH)
) u_mon (
  .sys_clk_i(sys_clk_i),
  .arst_n_i (arst_n_i),
  .sck_i    (sck_i),
  .cs_n_i   (cs_n_i),
  .si_i     (si_i),
  .wp_n_i   (wp_n_i),
  .so_o     (so_o),
  .so_oe_o  (so_oe_o)
);

// file: verif/sfs_spi_host.sv
// Purpose: spi host model driving the flash pins
// Assumes: 160 ns sck period, mode 0 or mode 3 idle level
// Notes:   si inverted when released, so no stale bit survives
`timescale 1ns/1ps
module sfs_spi_host (
  // spi pins
  output logic      sck_o,
  output logic      cs_n_o,
  output logic      si_o,
  input  wire logic so_i,
  input  wire logic so_oe_i
);
  logic m3;

  // idle: deselected, sck parked
  initial begin
    m3     = 1'b0;
    sck_o  = 1'b0;
    cs_n_o = 1'b1;
    si_o   = 1'b0;
  end

  // one framed instruction: nb bits out msb first, then nr bytes in
  task automatic frame(input logic [39:0] w, input int nb, input int nr, output logic [7:0] rd);
    rd = 8'h00;
    cs_n_o = 1'b0;
    #80;
    for (int i = nb - 1; i >= 0; i--) begin
      sck_o = 1'b0;
      si_o = w[i];
      #80 sck_o = 1'b1;
      #80;
    end
    for (int i = 0; i < 8 * nr; i++) begin
      sck_o = 1'b0;
      si_o = ~si_o;
      #80 sck_o = 1'b1;
      rd = {rd[6:0], so_oe_i ? so_i : 1'bx};
      #80;
    end
    sck_o = m3;
    #80 cs_n_o = 1'b1;
    si_o = ~si_o;
    #200;
  endtask
endmodule

// file: verif/sfs_flash_ctrl_tb.sv
// Purpose: self-checking bench for the serial flash controller
// Assumes: host model owns the spi pins, mode 0 unless switched
// Notes:   one block erase keeps erase time affordable
`timescale 1ns/1ps
module sfs_flash_ctrl_tb;
  import sfs_pkg::*;
  localparam logic [7:0] MFR = 8'h3C; // arbitrary value
  localparam logic [7:0] DEV = 8'hC3; // arbitrary value
  logic        clk, rst_n, wp_n, sck, cs_n, si, so, so_oe;
  logic        write_enable_latch, lock, auto_increment_program;
  logic [1:0]  lvl;
  logic [7:0]  rd;
  logic [7:0]  mem [int];
  logic [31:0] rng;
  int          bad_count, checked;

  // free-running system clock
  always #4 clk = ~clk;

  sfs_flash_ctrl #(.PROG_CYCLES(2), .MFR_CODE(MFR), .DEV_CODE(DEV)) dut (
    .sys_clk_i(clk), .arst_n_i(rst_n), .sck_i(sck), .cs_n_i(cs_n),
    .si_i(si), .wp_n_i(wp_n), .so_o(so), .so_oe_o(so_oe));

  sfs_spi_host host (.sck_o(sck), .cs_n_o(cs_n), .si_o(si), .so_i(so), .so_oe_i(so_oe));

  function automatic logic [7:0] rnd();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng[7:0];
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // frames start just after a clock edge
  task automatic cmd(input logic [39:0] w, input int nb, input int nr = 0);
    @(posedge clk);
    #1;
    host.frame(w, nb, nr, rd);
  endtask

  // second status byte proves the word keeps repeating
  task automatic st(input logic busy = 1'b0);
    cmd(40'h05, 8, 2);
    chk(rd, {lock, auto_increment_program, 2'b00, lvl, write_enable_latch, busy});
  endtask

  task automatic rdm(input logic [15:0] a, input int n);
    cmd({8'h03, 8'h00, a}, 32, n);
    chk(rd, mem[a + n - 1]);
  endtask

  task automatic poll();
    for (int n = 0; n < 200; n++) begin
      cmd(40'h05, 8, 1);
      if (rd[0] === 1'b0) return;
    end
    bad_count++;
    $display("[ERR] %0t busy never cleared", $time);
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // watchdog: run takes about 0.5 ms, limit stays under 100k clocks
  initial begin
    #760_000;
    bad_count++;
    report_and_stop();
  end

  // main sequence
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    wp_n = 1'b0;
    rng = 32'h358A;
    bad_count = 0;
    checked = 0;
    {write_enable_latch, lock, auto_increment_program, lvl} = 5'h03;
    repeat (6) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge clk);
    st();
    cmd(40'h01, 6);
    st();
    cmd(40'h06, 8);
    write_enable_latch = 1'b1;
    cmd({8'h02, 24'h00B005, 8'h11}, 40);
    cmd(40'h01FB, 16);
    st();
    cmd(40'h50, 8);
    cmd(40'h01FB, 16);
    {lock, lvl} = 3'h6;
    st();
    cmd(40'h50, 8);
    cmd(40'h0100, 16);
    st();
    @(posedge clk);
    #1 wp_n = 1'b1;
    cmd(40'h50, 8);
    cmd(40'h0104, 16);
    {lock, lvl} = 3'h1;
    st();
    cmd({8'h20, 24'h00C123}, 32);
    st();
    cmd(40'h60, 8);
    st();
    cmd({8'h52, 24'h00B123}, 32);
    write_enable_latch = 1'b0;
    st(1'b1);
    for (int i = 32'h8000; i < 32'h10000; i++) mem[i] = ERASED;
    poll();
    st();
    cmd({8'h02, 24'h00B005, 8'h5A}, 40);
    rdm(16'hB005, 1);
    cmd(40'h06, 8);
    mem[32'hB005] = rnd();
    cmd({8'h02, 24'h00B005, mem[32'hB005]}, 40);
    poll();
    st();
    rdm(16'hB004, 2);
    cmd(40'h06, 8);
    write_enable_latch = 1'b1;
    mem[32'hBFFD] = rnd();
    cmd({8'hAF, 24'h00BFFD, mem[32'hBFFD]}, 40);
    auto_increment_program = 1'b1;
    st();
    for (int i = 32'hBFFE; i < 32'hC000; i++) begin
      mem[i] = rnd();
      cmd({8'hAF, mem[i]}, 16);
    end
    {write_enable_latch, auto_increment_program} = 2'h0;
    st();
    for (int i = 32'hBFFD; i < 32'hC000; i++) rdm(i[15:0], 1);
    cmd(40'h06, 8);
    cmd({8'hAF, 24'h009000, rnd()}, 40);
    cmd(40'h04, 8);
    st();
    cmd(40'h06, 8);
    cmd({8'h20, 24'h00B123}, 32);
    for (int i = 32'hB000; i < 32'hC000; i++) mem[i] = ERASED;
    poll();
    st();
    rdm(16'hBFFE, 1);
    cmd({8'h90, 24'h000000}, 32, 2);
    chk(rd, MFR);
    cmd({8'hAB, 24'h000001}, 32, 1);
    chk(rd, DEV);
    host.m3 = 1'b1;
    st();
    st();
    host.m3 = 1'b0;
    st();
    report_and_stop();
  end
endmodule
